// ===== rtl/cswpll_pkg.sv
// Shared constants, types and helpers of the clock switch block
package cswpll_pkg;
  localparam logic [11:0] OFS_OSC = 12'h000;
  localparam logic [11:0] OFS_DIV = 12'h004;
  localparam int COSC_LSB = 12;
  localparam int NOSC_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int POSCEN_BIT = 2;
  localparam int SECONDARY_OSC_ENABLE_BIT = 1;
  localparam int SWITCH_REQUEST_BIT = 0;
  localparam int RC_POSTSCALE_LSB = 8;
  localparam int SYS_POSTSCALE_LSB = 6;
  localparam int PLL_ENABLE_BIT_BIT = 5;
  localparam logic [2:0] RC_POSTSCALE_RST = 3'h1;
  localparam logic [7:0] KEY_HI1 = 8'h78;
  localparam logic [7:0] KEY_HI2 = 8'h9a;
  localparam logic [7:0] KEY_LO1 = 8'h46;
  localparam logic [7:0] KEY_LO2 = 8'h57;
  localparam logic [3:0] SW_TICKS = 4'ha;
  localparam logic [4:0] PLL_MULT = 5'h18;
  localparam logic [4:0] SYS_FIX_DIV = 5'h03;
  localparam logic [1:0] USB_DIV = 2'h2;
  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_INTERNAL_RC_WITH_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRIPLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
  localparam logic [2:0] SRC_FRC16 = 3'h6;
  localparam logic [2:0] SRC_FRCDIV = 3'h7;

  typedef struct packed {
    logic switch_enable_cfg;
    logic [2:0] default_source_cfg;
    logic pll_enable_cfg;
    logic [2:0] pll_prescale_cfg;
    logic [1:0] primary_submode_cfg;
    logic watchdog_en;
  } cswpll_cfg_s;

  typedef struct packed {
    logic osc_startup_timer;
    logic pll_lock;
    logic new_clk_tick;
    logic clk_fail;
  } cswpll_osc_in_s;

  typedef struct packed {
    logic primary_osc_en;
    logic secondary_osc_en;
    logic fast_internal_rc_en;
    logic low_power_internal_rc_en;
    logic pll_en;
    logic [3:0] pll_prediv;
    logic [4:0] pll_mult;
    logic [4:0] sys_div;
    logic [1:0] usb_div;
    logic [2:0] rc_postscale;
  } cswpll_osc_out_s;

  function automatic logic uses_pll(input logic [2:0] s);
    return (s == SRC_INTERNAL_RC_WITH_PLL) || (s == SRC_PRIPLL);
  endfunction : uses_pll

  function automatic logic uses_pri(input logic [2:0] s);
    return (s == SRC_PRI) || (s == SRC_PRIPLL);
  endfunction : uses_pri

  function automatic logic uses_frc(input logic [2:0] s);
    return (s == SRC_FRC) || (s == SRC_INTERNAL_RC_WITH_PLL) ||
           (s == SRC_FRC16) || (s == SRC_FRCDIV);
  endfunction : uses_frc
endpackage : cswpll_pkg

// ===== rtl/cswpll_top.sv
// Clock source switch controller with PLL divider settings, APB slave
`timescale 1ns/1ps
`default_nettype none

//
// Summary of operation
// - Switching and clock monitor work only while switch-enable config is 0.
// - Switching disabled: selection ignored, current field shows default cfg.
// - Switching disabled: switch-request bit held at zero.
// - Upper byte write needs unlock writes 78h then 9Ah first.
// - Lower byte write needs unlock writes 46h then 57h first.
// - Request with equal current and new source is cleared as redundant.
// - Valid switch start clears PLL-lock bit, and clock-fail bit unless a clock fail arrives in that cycle.
// - Target oscillator turned on; crystal waits for start-up timer unless primary already runs.
// - PLL targets wait for PLL-lock bit set.
// - Ten new-clock cycles are counted before changeover.
// - Changeover clears request and copies new into current source.
// - Old source off; low-power RC and secondary kept when needed.
// - PLL multiplies 4 MHz by 24 into USB and system branches.
// - PLL enabled by its config bit or by the divider enable bit.
// - Prescaler division comes only from the prescale config bits.
// - System branch: postscaler, then fixed divide-by-3.
// - Postscale codes give 32, 16, 8 and 4 MHz.
// - USB branch is a fixed halving of the PLL output, 48 MHz.
// - Prescale codes divide by 12, 8, 6, 5, 4, 3, 2 and 1.
// - Three-bit source codes map to the eight clock sources.
module cswpll_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cswpll_pkg::cswpll_cfg_s cfg_i,
  input wire cswpll_pkg::cswpll_osc_in_s osc_i,
  output cswpll_pkg::cswpll_osc_out_s osc_o,
  output logic [2:0] clk_sel_o,
  output logic switching_o,
  output logic sys_clk_en_o
);
  import cswpll_pkg::*;

  typedef enum logic [4:0] {
    UL_IDLE = 5'b00001,
    UL_H1 = 5'b00010,
    UL_HOK = 5'b00100,
    UL_L1 = 5'b01000,
    UL_LOK = 5'b10000
  } cswpll_ul_e;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_COUNT = 3'b100
  } cswpll_sw_e;

  cswpll_ul_e ul_r, ul_nxt;
  cswpll_sw_e sw_r, sw_nxt;
  logic init_r;
  logic [2:0] cosc_r, cosc_nxt;
  logic [2:0] nosc_r, nosc_nxt;
  logic [2:0] tgt_r;
  logic lock_r, lock_nxt;
  logic cf_r, cf_nxt;
  logic poscen_r, secondary_osc_enable_r;
  logic switch_request_r, switch_request_nxt;
  logic [2:0] rc_postscale_r;
  logic [1:0] sys_postscale_r;
  logic pll_enable_bit_r;
  logic [3:0] cnt_r;
  logic [4:0] sdc_r;
  logic [31:0] prdata_r;

  // Decode
  wire switch_en = ~cfg_i.switch_enable_cfg;
  wire failsafe_clock_monitor_en = switch_en;
  wire sel_osc = (paddr == OFS_OSC);
  wire sel_div = (paddr == OFS_DIV);
  wire mapped = sel_osc | sel_div;
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire wr_osc = wr_en & sel_osc;
  wire wr_div = wr_en & sel_div;
  wire hi_only = (pstrb == 4'b0010);
  wire lo_only = (pstrb == 4'b0001);
  wire key_h1 = wr_osc & hi_only & (pwdata[15:8] == KEY_HI1);
  wire key_h2 = wr_osc & hi_only & (pwdata[15:8] == KEY_HI2);
  wire key_l1 = wr_osc & lo_only & (pwdata[7:0] == KEY_LO1);
  wire key_l2 = wr_osc & lo_only & (pwdata[7:0] == KEY_LO2);
  wire wr_hi_ok = wr_osc & pstrb[1] & (ul_r == UL_HOK);
  wire wr_lo_ok = wr_osc & pstrb[0] & (ul_r == UL_LOK);

  // Switch sequencing terms
  wire busy = (sw_r != SW_IDLE);
  wire sw_idle = (sw_r == SW_IDLE);
  wire req = sw_idle & switch_request_r & switch_en & init_r;
  wire redundant = req & (nosc_r == cosc_r);
  wire start = req & (nosc_r != cosc_r);
  wire crystal = (cfg_i.primary_submode_cfg != SUB_EC);
  // Primary already running needs no start-up wait
  wire need_ost = uses_pri(tgt_r) & crystal & ~uses_pri(cosc_r);
  wire need_lock = uses_pll(tgt_r);
  wire src_ready = (~need_ost | osc_i.osc_startup_timer) &
                   (~need_lock | lock_r);
  wire tick = osc_i.new_clk_tick;
  wire last_tick = tick & (cnt_r == SW_TICKS - 4'h1);
  wire done = (sw_r == SW_COUNT) & last_tick;
  wire fail_set = osc_i.clk_fail & failsafe_clock_monitor_en;
  wire pll_on = cfg_i.pll_enable_cfg | pll_enable_bit_r |
                uses_pll(cosc_r) | (busy & uses_pll(tgt_r));
  wire pll_active = pll_on & (uses_pll(cosc_r) |
                    (busy & uses_pll(tgt_r)));
  wire [4:0] sys_div = SYS_FIX_DIV << sys_postscale_r;
  wire sdc_wrap = (sdc_r >= sys_div - 5'h01);

  // Unlock detector
  always_comb begin
    ul_nxt = ul_r;
    if (wr_en) begin
      unique case (ul_r)
        UL_IDLE: begin
          if (key_h1) ul_nxt = UL_H1;
          else if (key_l1) ul_nxt = UL_L1;
          else ul_nxt = UL_IDLE;
        end
        UL_H1: ul_nxt = key_h2 ? UL_HOK : UL_IDLE;
        UL_L1: ul_nxt = key_l2 ? UL_LOK : UL_IDLE;
        UL_HOK: ul_nxt = UL_IDLE;
        UL_LOK: ul_nxt = UL_IDLE;
        default: ul_nxt = UL_IDLE;
      endcase
    end
  end

  // Switch sequencer
  always_comb begin
    sw_nxt = sw_r;
    unique case (sw_r)
      SW_IDLE: if (start) sw_nxt = SW_WAIT;
      SW_WAIT: if (src_ready) sw_nxt = SW_COUNT;
      SW_COUNT: if (last_tick) sw_nxt = SW_IDLE;
      default: sw_nxt = SW_IDLE;
    endcase
  end

  // Current and new source fields
  always_comb begin
    cosc_nxt = cosc_r;
    if (~init_r | ~switch_en) cosc_nxt = cfg_i.default_source_cfg;
    else if (done) cosc_nxt = tgt_r;
    nosc_nxt = nosc_r;
    if (~init_r) nosc_nxt = cfg_i.default_source_cfg;
    else if (wr_hi_ok) nosc_nxt = pwdata[NOSC_LSB +: 3];
  end

  // Request bit; software set wins over hardware clear
  always_comb begin
    if (~switch_en) switch_request_nxt = 1'b0;
    else if (wr_lo_ok) switch_request_nxt = pwdata[SWITCH_REQUEST_BIT];
    else if (redundant | done) switch_request_nxt = 1'b0;
    else switch_request_nxt = switch_request_r;
  end

  // Lock and clock-fail flags
  always_comb begin
    lock_nxt = start ? 1'b0 : (pll_active & osc_i.pll_lock);
    if (fail_set) cf_nxt = 1'b1;
    else if (start) cf_nxt = 1'b0;
    else if (wr_lo_ok & ~pwdata[CF_BIT]) cf_nxt = 1'b0;
    else cf_nxt = cf_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ul_r <= UL_IDLE;
      sw_r <= SW_IDLE;
      init_r <= 1'b0;
      cosc_r <= SRC_FRC;
      nosc_r <= SRC_FRC;
      tgt_r <= SRC_FRC;
      lock_r <= 1'b0;
      cf_r <= 1'b0;
      switch_request_r <= 1'b0;
    end else begin
      ul_r <= ul_nxt;
      sw_r <= sw_nxt;
      init_r <= 1'b1;
      cosc_r <= cosc_nxt;
      nosc_r <= nosc_nxt;
      if (start) tgt_r <= nosc_r;
      lock_r <= lock_nxt;
      cf_r <= cf_nxt;
      switch_request_r <= switch_request_nxt;
    end
  end

  // Low byte controls and divider register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poscen_r <= 1'b0;
      secondary_osc_enable_r <= 1'b0;
      rc_postscale_r <= RC_POSTSCALE_RST;
      sys_postscale_r <= 2'h0;
      pll_enable_bit_r <= 1'b0;
    end else begin
      if (wr_lo_ok) begin
        poscen_r <= pwdata[POSCEN_BIT];
        secondary_osc_enable_r <= pwdata[SECONDARY_OSC_ENABLE_BIT];
      end
      if (wr_div & pstrb[1]) rc_postscale_r <= pwdata[RC_POSTSCALE_LSB +: 3];
      if (wr_div & pstrb[0]) begin
        sys_postscale_r <= pwdata[SYS_POSTSCALE_LSB +: 2];
        pll_enable_bit_r <= pwdata[PLL_ENABLE_BIT_BIT];
      end
    end
  end

  // New-clock cycle counter and system clock enable divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      sdc_r <= 5'h00;
    end else begin
      if (sw_r != SW_COUNT) cnt_r <= 4'h0;
      else if (tick) cnt_r <= cnt_r + 4'h1;
      sdc_r <= sdc_wrap ? 5'h00 : sdc_r + 5'h01;
    end
  end

  // Read data captured in setup so it is stable over access
  wire [31:0] osc_rd = {17'h0, cosc_r, 1'b0, nosc_r, 2'h0, lock_r,
                        1'b0, cf_r, poscen_r, secondary_osc_enable_r, switch_request_r};
  wire [31:0] div_rd = {21'h0, rc_postscale_r, sys_postscale_r, pll_enable_bit_r, 5'h00};
  wire [31:0] rd_mux = sel_osc ? osc_rd : (sel_div ? div_rd : 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h0;
    else if (rd_setup) prdata_r <= rd_mux;
  end

  // Prescaler table, from configuration only
  function automatic logic [3:0] prediv(input logic [2:0] c);
    unique case (c)
      3'h7: return 4'hc;
      3'h6: return 4'h8;
      3'h5: return 4'h6;
      3'h4: return 4'h5;
      3'h3: return 4'h4;
      3'h2: return 4'h3;
      3'h1: return 4'h2;
      3'h0: return 4'h1;
    endcase
  endfunction : prediv

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign clk_sel_o = cosc_r;
  assign switching_o = busy;
  assign sys_clk_en_o = sdc_wrap;
  // Old source drops once current field moves on
  assign osc_o.primary_osc_en = uses_pri(cosc_r) |
                                (busy & uses_pri(tgt_r));
  assign osc_o.fast_internal_rc_en = uses_frc(cosc_r) |
                                     (busy & uses_frc(tgt_r));
  assign osc_o.secondary_osc_en = (cosc_r == SRC_SEC) | secondary_osc_enable_r |
                                  (busy & tgt_r == SRC_SEC);
  // Low-power RC must survive for watchdog and clock monitor
  assign osc_o.low_power_internal_rc_en = (cosc_r == SRC_LOW_POWER_INTERNAL_RC) |
    (busy & tgt_r == SRC_LOW_POWER_INTERNAL_RC) | cfg_i.watchdog_en | failsafe_clock_monitor_en;
  assign osc_o.pll_en = pll_on;
  assign osc_o.pll_prediv = prediv(cfg_i.pll_prescale_cfg);
  assign osc_o.pll_mult = PLL_MULT;
  assign osc_o.sys_div = sys_div;
  assign osc_o.usb_div = USB_DIV;
  assign osc_o.rc_postscale = rc_postscale_r;

  // One clock domain, so all checks share clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_hold_zero;
    !switch_en |=> !switch_request_r;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("request bit set while switching disabled");

  property p_cosc_cfg;
    !switch_en |=> cosc_r == $past(cfg_i.default_source_cfg);
  endproperty
  a_cosc_cfg: assert property (p_cosc_cfg)
    else $error("current source differs from default config");

  property p_redundant;
    redundant && !wr_lo_ok |=> !switch_request_r && sw_r == SW_IDLE;
  endproperty
  a_redundant: assert property (p_redundant)
    else $error("redundant switch not aborted");

  property p_start_clr;
    start && !fail_set |=> !lock_r && !cf_r && sw_r == SW_WAIT;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("lock or fail flag kept at switch start");

  property p_lock_wait;
    sw_r == SW_WAIT && need_lock && !lock_r |=> sw_r != SW_COUNT;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("switch went on without PLL lock");

  property p_ten;
    init_r && switch_en && $past(switch_en) && $past(init_r) &&
    $changed(cosc_r) |-> $past(sw_r) == SW_COUNT &&
    $past(cnt_r) == 4'h9 && $past(tick);
  endproperty
  a_ten: assert property (p_ten)
    else $error("changeover without ten new-clock cycles");

  property p_done;
    done |=> cosc_r == $past(tgt_r) && sw_r == SW_IDLE &&
    (!switch_request_r || $past(wr_lo_ok));
  endproperty
  a_done: assert property (p_done)
    else $error("changeover did not update fields");

  property p_unlock_hi;
    init_r && $past(init_r) && $changed(nosc_r) |->
    $past(ul_r) == UL_HOK && $past(wr_osc);
  endproperty
  a_unlock_hi: assert property (p_unlock_hi)
    else $error("new source written without unlock");

  property p_rearm;
    wr_en && !sel_osc |=> ul_r == UL_IDLE;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("unlock not re-armed by stray write");

  property p_pll_en;
    cfg_i.pll_enable_cfg || pll_enable_bit_r |-> osc_o.pll_en;
  endproperty
  a_pll_en: assert property (p_pll_en)
    else $error("PLL not enabled");

  property p_prediv;
    cfg_i.pll_prescale_cfg == 3'h7 |-> osc_o.pll_prediv == 4'hc;
  endproperty
  a_prediv: assert property (p_prediv)
    else $error("prescale 111 not divide by 12");

  c_redundant: cover property (redundant);
  c_switch_done: cover property (start ##[1:200] done);
  c_hi_write: cover property (wr_hi_ok);
  c_lo_write: cover property (wr_lo_ok && pwdata[SWITCH_REQUEST_BIT]);
  c_clk_fail: cover property (fail_set && !start);
endmodule : cswpll_top

`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the clock switch controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cswpll_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cswpll_cfg_s cfg;
  cswpll_osc_in_s osc;
  cswpll_osc_out_s oo;
  logic [2:0] clk_sel;
  logic switching;
  logic sys_en;
  logic [31:0] rd;
  logic er;
  logic [31:0] d;
  logic [2:0] src;
  int num_errors = 0;
  int comparisons = 0;
  int pulses;
  int m_cosc, m_nosc, m_lock, m_cf, m_secondary_osc, m_req;
  int div_q[$] = '{1, 2, 3, 4, 5, 6, 8, 12};

  always #12.5 pclk = ~pclk;

  cswpll_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_i(cfg), .osc_i(osc), .osc_o(oo), .clk_sel_o(clk_sel),
    .switching_o(switching), .sys_clk_en_o(sys_en));

  task close_out;
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Model of the oscillator control word; primary sleep bit stays 0
  function automatic logic [31:0] osc_exp();
    return 32'((m_cosc << 12) | (m_nosc << 8) | (m_lock << 5) |
      (m_cf << 3) | (m_secondary_osc << 1) | m_req);
  endfunction : osc_exp

  function automatic logic [31:0] ln(input logic hi, input logic [7:0] b);
    return hi ? {16'h0, b, 8'h0} : {24'h0, b};
  endfunction : ln

  // Slave may stall; wait bounded, release only after pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rdchk

  task prot(input logic hi, input logic [7:0] v);
    apb(1'b1, OFS_OSC, ln(hi, hi ? KEY_HI1 : KEY_LO1), hi ? 4'h2 : 4'h1);
    apb(1'b1, OFS_OSC, ln(hi, hi ? KEY_HI2 : KEY_LO2), hi ? 4'h2 : 4'h1);
    apb(1'b1, OFS_OSC, ln(hi, v), hi ? 4'h2 : 4'h1);
  endtask : prot

  // Waits n edges, then samples settled outputs at the falling edge
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : cyc

  task ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      osc.new_clk_tick <= 1'b1;
      @(posedge pclk);
      osc.new_clk_tick <= 1'b0;
    end
  endtask : ticks

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    m_cosc = int'(cfg.default_source_cfg);
    m_nosc = m_cosc;
    m_lock = 0;
    m_cf = 0;
    m_secondary_osc = 0;
    m_req = 0;
  endtask : do_reset

  initial begin
    cfg = '0;
    cfg.primary_submode_cfg = 2'h1;
    cfg.watchdog_en = 1'b1;
    osc = '0;
    void'($urandom(77));
    do_reset();
    rdchk(OFS_OSC, osc_exp());
    rdchk(OFS_DIV, 32'(RC_POSTSCALE_RST) << RC_POSTSCALE_LSB);
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      cfg.pll_prescale_cfg <= 3'(i);
      cyc(1);
      chk(32'(oo.pll_prediv), div_q[i]);
    end
    for (int i = 0; i < 4; i++) begin
      src = 3'($urandom_range(7, 0));
      d = (32'(src) << 8) | (32'(i) << 6) | (32'(i & 1) << 5);
      apb(1'b1, OFS_DIV, d, 4'hf);
      rdchk(OFS_DIV, d);
      cyc(1);
      chk(32'(oo.sys_div), 3 << i);
      chk(32'(oo.pll_en), i & 1);
      chk(32'(oo.pll_mult), 24);
      chk(32'(oo.usb_div), 2);
      chk(32'(oo.rc_postscale), 32'(src));
    end
    pulses = 0;
    repeat (48) begin
      @(negedge pclk);
      if (sys_en === 1'b1) pulses++;
    end
    chk(32'(pulses), 32'h2);
    src = 3'($urandom_range(7, 1));
    apb(1'b1, OFS_OSC, ln(1'b1, KEY_HI1), 4'h2);
    apb(1'b1, OFS_DIV, d, 4'hf);
    apb(1'b1, OFS_OSC, ln(1'b1, KEY_HI2), 4'h2);
    apb(1'b1, OFS_OSC, ln(1'b1, {5'h0, src}), 4'h2);
    apb(1'b1, OFS_OSC, 32'h1, 4'h1);
    rdchk(OFS_OSC, osc_exp());
    prot(1'b1, {5'h0, src});
    m_nosc = int'(src);
    rdchk(OFS_OSC, osc_exp());
    prot(1'b1, {5'h0, SRC_FRC});
    m_nosc = 0;
    prot(1'b0, 8'h01);
    cyc(3);
    chk(32'(switching), 32'h0);
    rdchk(OFS_OSC, osc_exp());
    prot(1'b1, {5'h0, SRC_PRIPLL});
    m_nosc = 3;
    prot(1'b0, 8'h01);
    cyc(2);
    chk(32'(switching), 32'h1);
    chk(32'(oo.primary_osc_en), 32'h1);
    // Lock drops before start-up expires, so a stale lock bit cannot pass
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      osc.pll_lock <= (p == 0);
      repeat (2) @(posedge pclk);
      osc.osc_startup_timer <= (p == 1);
      cyc(3);
      ticks(12);
      cyc(0);
      chk(32'(clk_sel), 32'(SRC_FRC));
    end
    @(posedge pclk);
    osc.osc_startup_timer <= 1'b1;
    osc.pll_lock <= 1'b1;
    cyc(3);
    ticks(9);
    cyc(0);
    chk(32'(clk_sel), 32'(SRC_FRC));
    ticks(1);
    cyc(0);
    chk(32'(clk_sel), 32'(SRC_PRIPLL));
    chk(32'(switching), 32'h0);
    m_cosc = 3;
    m_lock = 1;
    rdchk(OFS_OSC, osc_exp());
    @(posedge pclk);
    osc.clk_fail <= 1'b1;
    @(posedge pclk);
    osc.clk_fail <= 1'b0;
    m_cf = 1;
    rdchk(OFS_OSC, osc_exp());
    prot(1'b1, {5'h0, SRC_FRC});
    m_nosc = 0;
    prot(1'b0, 8'h0b);
    m_secondary_osc = 1;
    cyc(2);
    apb(1'b0, OFS_OSC, 32'h0, 4'h0);
    chk(32'(rd[CF_BIT]), 32'h0);
    chk(32'(rd[SWITCH_REQUEST_BIT]), 32'h1);
    @(posedge pclk);
    osc.pll_lock <= 1'b0;
    cyc(3);
    ticks(10);
    cyc(0);
    chk(32'(clk_sel), 32'(SRC_FRC));
    chk(32'(oo.primary_osc_en), 32'h0);
    chk(32'(oo.secondary_osc_en), 32'h1);
    chk(32'(oo.low_power_internal_rc_en), 32'h1);
    chk(32'(oo.fast_internal_rc_en), 32'h1);
    m_cosc = 0;
    m_lock = 0;
    m_cf = 0;
    rdchk(OFS_OSC, osc_exp());
    // Switch-enable, default source and watchdog config change only around a reset
    @(posedge pclk);
    cfg.switch_enable_cfg <= 1'b1;
    cfg.default_source_cfg <= SRC_SEC;
    cfg.watchdog_en <= 1'b0;
    do_reset();
    prot(1'b1, {5'h0, SRC_LOW_POWER_INTERNAL_RC});
    prot(1'b0, 8'h01);
    cyc(3);
    chk(32'(switching), 32'h0);
    chk(32'(clk_sel), 32'(SRC_SEC));
    chk(32'(oo.low_power_internal_rc_en), 32'h0);
    apb(1'b0, OFS_OSC, 32'h0, 4'h0);
    chk(32'(rd[14:12]), 32'(SRC_SEC));
    chk(32'(rd[SWITCH_REQUEST_BIT]), 32'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
